// ===== bench/output_power_timing_config_regs_tb_top.sv
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch at %0t: got %0h want %0h", $time, a, e); \
  end \
end
module output_power_timing_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, v;
  logic power_down_pin_i = 1'b0, sync_detected_i = 1'b1, reg_ack_o, p;
  logic [3:0] st = 4'h0, link_ctrl_i = 4'h0, i2s_audio_i = 4'h0, i2s_o;
  logic [5:0] lnk = 6'h00;
  logic [1:0] out_mode_i = 2'h1, aud_mode_o, f;
  logic [23:0] pixel_i = 24'h000000;
  logic [7:0] secondary_i = 8'h00;
  logic [29:0] data_o, data_oe_o, bus;
  logic hs, vs, pck, sync_io_oe_o, de, sog, sog_oe_o, i2s_oe_o, spdif;
  logic spdif_oe_o, key, ext, chip_powered_o, bt, pde;
  logic [4:0] aud_width_o;
  logic [3:0] i2s_bus;
  logic [8:0] exp_q [$];
  logic [8:0] note;
  int n_mismatch = 0, total_checks = 0;
  logic [7:0] rst [11] = '{opt_cfg_pkg::SEC_OUT_RST, opt_cfg_pkg::TRI_PWR_RST,
    opt_cfg_pkg::AUTO_PWR_RST, {opt_cfg_pkg::VDLY_RST,
    opt_cfg_pkg::HDLY_RST[9:8]}, opt_cfg_pkg::HDLY_RST[7:0],
    {4'h0, opt_cfg_pkg::LWID_RST[11:8]}, opt_cfg_pkg::LWID_RST[7:0],
    {4'h0, opt_cfg_pkg::SHGT_RST[11:8]}, opt_cfg_pkg::SHGT_RST[7:0],
    opt_cfg_pkg::AUD_CFG_RST, 8'h00};
  output_power_timing_config_regs DUT (.mclk_i(mclk_i), .srst_i(srst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .power_down_pin_i(power_down_pin_i),
    .sync_detected_i(sync_detected_i), .tmds_de_i(st[3]),
    .tmds_clk_i(st[2]), .av_mute_i(st[1]), .keys_read_i(st[0]),
    .link_hsync_i(lnk[0]), .link_vsync_i(lnk[1]), .link_de_i(lnk[2]),
    .link_mode_i(lnk[3]), .out_mode_i(out_mode_i), .pixel_i(pixel_i),
    .secondary_i(secondary_i), .link_ctrl_i(link_ctrl_i),
    .i2s_audio_i(i2s_audio_i), .spdif_i(lnk[4]), .sog_i(lnk[5]),
    .data_o(data_o), .data_oe_o(data_oe_o), .horizontal_sync_output_o(hs),
    .vertical_sync_output_o(vs), .output_pixel_clock_o(pck),
    .sync_io_oe_o(sync_io_oe_o), .display_enable_o(de),
    .sync_on_green_output_o(sog), .sog_oe_o(sog_oe_o), .i2s_o(i2s_o),
    .i2s_oe_o(i2s_oe_o), .spdif_o(spdif), .spdif_oe_o(spdif_oe_o),
    .key_exchange_address_lsb_o(key), .ext_mclk_sel_o(ext),
    .chip_powered_o(chip_powered_o), .bt656_marker_o(bt),
    .aud_mode_o(aud_mode_o), .aud_width_o(aud_width_o));
  video_sink sink (.mclk_i(mclk_i), .data_i(data_o), .oe_i(data_oe_o),
    .i2s_i(i2s_o), .i2s_oe_i(i2s_oe_o), .bus_o(bus), .i2s_bus_o(i2s_bus));
  always #10 mclk_i = ~mclk_i;
  // link traffic shares mclk_i, so any audio clock stays locked to it
  always @(negedge mclk_i) begin
    lnk     <= 6'($urandom);
    pixel_i <= 24'($urandom);
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i    = wr;
    reg_rd_i    = ~wr;
    reg_addr_i  = a;
    reg_wdata_i = d;
    exp_q.push_back({~wr, d});
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask : acc
  task automatic lvl(input logic [7:0] d, input logic [4:0] o);
    `CHK({data_oe_o[7:0], sync_io_oe_o, sog_oe_o, i2s_oe_o, spdif_oe_o,
      chip_powered_o}, {d, o})
  endtask : lvl
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // every ack pops one note; reads compare data, writes are popped unchecked
  always @(negedge mclk_i) begin
    if (reg_ack_o === 1'b1) begin
      note = exp_q.pop_front();
      if (note[8] === 1'b1) `CHK(reg_rdata_o, note[7:0])
    end
  end
  initial begin
    #80000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'h96377702));
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    foreach (rst[i]) acc(1'b0, 8'h25 + 8'(i), rst[i]);
    acc(1'b0, 8'h30, 8'h00);
    lvl(8'h00, 5'h1F);
    `CHK({aud_mode_o, aud_width_o, key, ext}, 9'h060)
    $display("test reset values done");
    for (int a = 8'h25; a < 8'h31; a++) begin
      v  = 8'($urandom);
      st = 4'($urandom);
      acc(1'b1, 8'(a), v);
      if (a == 8'h2A || a == 8'h2C) v = v & 8'h0F;
      if (a >= 8'h2F) v = (a == 8'h2F) ? {1'b0, st, 3'h0} : 8'h00;
      acc(1'b0, 8'(a), v);
    end
    $display("test readback done");
    acc(1'b1, opt_cfg_pkg::SEC_OUT_CTRL_ADDR, 8'h01);
    for (int k = 0; k < 16; k++) begin
      acc(1'b1, opt_cfg_pkg::TRI_PWR_ADDR, {4'(k), 4'h8});
      lvl(k[3] ? 8'h00 : 8'hFF, {~k[3], ~k[2], ~(k[3] | k[0]),
        ~(k[3] | k[1]), 1'b1});
    end
    acc(1'b1, opt_cfg_pkg::TRI_PWR_ADDR, 8'h09);
    `CHK({data_oe_o[7:0], sync_io_oe_o, sog_oe_o}, 10'h001)
    for (int k = 0; k < 8; k++) begin
      {p, f} = 3'(k);
      acc(1'b1, opt_cfg_pkg::TRI_PWR_ADDR, {4'h0, p, f, 1'b0});
      power_down_pin_i = p;
      repeat (3) @(negedge mclk_i);
      lvl(8'h00, {1'b0, ~f[0], 2'b00, f[1]});
      power_down_pin_i = ~p;
      repeat (3) @(negedge mclk_i);
      lvl(8'hFF, 5'h1F);
    end
    $display("test three-state and power-down done");
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      v[7:5] = 3'(k);
      acc(1'b1, opt_cfg_pkg::AUTO_PWR_ADDR, v);
      sync_detected_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      `CHK({chip_powered_o, key, ext}, {~v[7], v[6:5]})
      sync_detected_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      `CHK(chip_powered_o, 1'b1)
    end
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      v[7:5] = 3'(k);
      link_ctrl_i = 4'($urandom);
      i2s_audio_i = 4'($urandom);
      acc(1'b1, opt_cfg_pkg::AUD_CFG_ADDR, v);
      repeat (2) @(negedge mclk_i);
      `CHK({aud_mode_o, aud_width_o}, v[6:0])
      `CHK(i2s_bus, v[7] ? link_ctrl_i : i2s_audio_i)
    end
    for (int k = 1; k < 3; k++) begin
      out_mode_i  = 2'(k);
      secondary_i = 8'($urandom);
      repeat (2) @(negedge mclk_i);
      `CHK(bus[7:0], secondary_i)
    end
    acc(1'b1, opt_cfg_pkg::AUTO_PWR_ADDR, 8'h10);
    out_mode_i = 2'h0;
    @(negedge mclk_i);
    for (int k = 0; k < 8; k++) begin
      p   = pck;
      pde = de;
      @(negedge mclk_i);
      `CHK({sog, spdif, de, vs, hs}, {lnk[5:4], lnk[2:0]})
      `CHK(data_o, {6'h00, pixel_i})
      `CHK(pck, ~p)
      `CHK(bt, de ^ pde)
    end
    $display("test fields and data done");
    repeat (4) @(negedge mclk_i);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule : output_power_timing_config_regs_tb_top

// ===== bench/video_sink.sv
module video_sink (
  input  wire logic        mclk_i,
  input  wire logic [29:0] data_i,
  input  wire logic [29:0] oe_i,
  input  wire logic [3:0]  i2s_i,
  input  wire logic        i2s_oe_i,
  output logic      [29:0] bus_o,
  output logic      [3:0]  i2s_bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] last_q;
  logic [3:0]  last_i2s_q;
  // released lines flip each cycle so a stale level never passes
  always_comb begin
    bus_o     = (data_i & oe_i) | (~last_q & ~oe_i);
    i2s_bus_o = i2s_oe_i ? i2s_i : ~last_i2s_q;
  end
  always_ff @(posedge mclk_i) begin
    last_q     <= bus_o;
    last_i2s_q <= i2s_bus_o;
  end
endmodule : video_sink

// ===== core/opt_cfg_pkg.sv
package opt_cfg_pkg;
  localparam logic [7:0] SEC_OUT_CTRL_ADDR = 8'h25;
  localparam logic [7:0] TRI_PWR_ADDR      = 8'h26;
  localparam logic [7:0] AUTO_PWR_ADDR     = 8'h27;
  localparam logic [7:0] VDLY_HDLYH_ADDR   = 8'h28;
  localparam logic [7:0] HDLY_LOW_ADDR     = 8'h29;
  localparam logic [7:0] LWID_HIGH_ADDR    = 8'h2A;
  localparam logic [7:0] LWID_LOW_ADDR     = 8'h2B;
  localparam logic [7:0] SHGT_HIGH_ADDR    = 8'h2C;
  localparam logic [7:0] SHGT_LOW_ADDR     = 8'h2D;
  localparam logic [7:0] AUD_CFG_ADDR      = 8'h2E;
  localparam logic [7:0] LINK_STAT_ADDR    = 8'h2F;
  localparam int SEC_EN_BIT   = 0;
  localparam int GLB_TRI_BIT  = 7;
  localparam int SOG_TRI_BIT  = 6;
  localparam int SPDIF_TRI_BIT = 5;
  localparam int I2S_TRI_BIT  = 4;
  localparam int PD_POL_BIT   = 3;
  localparam int PD_FN_LSB    = 1;
  localparam int SW_PD_BIT    = 0;
  localparam int AUTO_PD_BIT  = 7;
  localparam int KEY_LSB_BIT  = 6;
  localparam int EXT_MCLK_BIT = 5;
  localparam int BT656_BIT    = 4;
  localparam int FORCE_DE_BIT = 3;
  localparam int CTRL_EN_BIT  = 7;
  localparam int AUD_MODE_LSB = 5;
  localparam logic [7:0] SEC_OUT_RST = 8'h00;
  localparam logic [7:0] TRI_PWR_RST = 8'h08;
  localparam logic [7:0] AUTO_PWR_RST = 8'h80;
  localparam logic [5:0] VDLY_RST    = 6'h18;
  localparam logic [9:0] HDLY_RST    = 10'h104;
  localparam logic [11:0] LWID_RST   = 12'h500;
  localparam logic [11:0] SHGT_RST   = 12'h2D0;
  localparam logic [7:0] AUD_CFG_RST = 8'h18;
  localparam logic [1:0] AUD_I2S     = 2'h0;
  localparam logic [1:0] AUD_RJ      = 2'h1;
  localparam logic [1:0] AUD_LJ      = 2'h2;
  localparam logic [1:0] AUD_RAW     = 2'h3;
  localparam logic [1:0] PDF_OFF_SOG = 2'h0;
  localparam logic [1:0] PDF_OFF_ALL = 2'h1;
  localparam logic [1:0] PDF_ON_SOG  = 2'h2;
  localparam logic [1:0] PDF_ON_ALL  = 2'h3;
endpackage : opt_cfg_pkg

// ===== core/output_power_timing_config_regs.sv
// How it works
// - secondary enable low floats secondary outputs
// - secondary data carried on blue, DDR YCrCb
// - global three-state floats all but sync-on-green
// - separate floats for sog, spdif, i2s pins
// - power-down pin polarity bit, resets high
// - pin function selects power and float set
// - pin function acts only while pin asserted
// - software power-down floats syncs, clock, data
// - sync logic and registers stay alive powered down
// - auto power-down when no sync detected
// - bit gives key exchange address lsb
// - select internal or external audio master clock
// - bt656 inserts sav/eav markers from timing
// - force display enable from internal generator while link_mode_i high
// - interlace offset in hsyncs between fields
// - vertical delay lines after vsync edge
// - horizontal delay pixels after hsync edge
// - active width and height for generator
// - control signals replace audio on i2s pins
// - audio serial mode and justified width
// - read-only link status bits
module output_power_timing_config_regs (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_ack_o,
  input  wire logic        power_down_pin_i,
  input  wire logic        sync_detected_i,
  input  wire logic        tmds_de_i,
  input  wire logic        tmds_clk_i,
  input  wire logic        av_mute_i,
  input  wire logic        keys_read_i,
  input  wire logic        link_hsync_i,
  input  wire logic        link_vsync_i,
  input  wire logic        link_de_i,
  input  wire logic        link_mode_i,
  input  wire logic [1:0]  out_mode_i,
  input  wire logic [23:0] pixel_i,
  input  wire logic [7:0]  secondary_i,
  input  wire logic [3:0]  link_ctrl_i,
  input  wire logic [3:0]  i2s_audio_i,
  input  wire logic        spdif_i,
  input  wire logic        sog_i,
  output logic      [29:0] data_o,
  output logic      [29:0] data_oe_o,
  output logic             horizontal_sync_output_o,
  output logic             vertical_sync_output_o,
  output logic             output_pixel_clock_o,
  output logic             sync_io_oe_o,
  output logic             display_enable_o,
  output logic             sync_on_green_output_o,
  output logic             sog_oe_o,
  output logic [3:0]       i2s_o,
  output logic             i2s_oe_o,
  output logic             spdif_o,
  output logic             spdif_oe_o,
  output logic             key_exchange_address_lsb_o,
  output logic             ext_mclk_sel_o,
  output logic             chip_powered_o,
  output logic             bt656_marker_o,
  output logic [1:0]       aud_mode_o,
  output logic [4:0]       aud_width_o
);
  typedef struct packed {
    logic [7:0]  sec_q;
    logic [7:0]  tri_q;
    logic [7:0]  auto_q;
    logic [5:0]  vdly_q;
    logic [9:0]  hdly_q;
    logic [11:0] lwid_q;
    logic [11:0] shgt_q;
    logic [7:0]  aud_q;
    logic [1:0]  pd_s_q;
    logic [1:0]  sd_s_q;
    logic        hs_q;
    logic        vs_q;
    logic [11:0] hcnt_q;
    logic [11:0] vcnt_q;
    logic        field_q;
    logic        de_q;
    logic        mark_q;
    logic        clk_q;
    logic [7:0]  rdata_q;
    logic        ack_q;
    logic [29:0] data_q;
    logic        hso_q;
    logic        vso_q;
    logic        sog_q;
    logic [3:0]  i2s_q;
    logic        spdif_q;
  } state_t;
  state_t q;
  state_t d;
  logic pin_act;
  logic pd_float;
  logic pd_all;
  logic powered;
  logic main_oe;
  logic sog_oe;
  logic [11:0] h_start;
  logic [11:0] v_start;
  logic gen_de;
  logic de_sel;
  logic [7:0] status;

  // pin level: polarity bit makes asserted state
  assign pin_act = q.pd_s_q[1] ~^ q.tri_q[opt_cfg_pkg::PD_POL_BIT];
  assign pd_float = pin_act;
  assign pd_all = pin_act &&
      q.tri_q[opt_cfg_pkg::PD_FN_LSB];
  // fn codes 00/01 power down; 10/11 stay up
  assign powered = !(pin_act && !q.tri_q[opt_cfg_pkg::PD_FN_LSB+1])
      && !q.tri_q[opt_cfg_pkg::SW_PD_BIT]
      && !(q.auto_q[opt_cfg_pkg::AUTO_PD_BIT] && !q.sd_s_q[1]);
  assign main_oe = !q.tri_q[opt_cfg_pkg::GLB_TRI_BIT]
      && !q.tri_q[opt_cfg_pkg::SW_PD_BIT]
      && !pd_float;
  assign sog_oe = !q.tri_q[opt_cfg_pkg::SOG_TRI_BIT] && !pd_all;
  assign status = {1'b0, tmds_de_i, tmds_clk_i, av_mute_i,
      keys_read_i, 3'h0};

  // generator start points include programmed delays
  assign h_start = {2'h0, q.hdly_q};
  assign v_start = {6'h00, q.vdly_q}
      + (q.field_q ? {9'h000, q.auto_q[2:0]} : 12'h000);
  assign gen_de = (q.hcnt_q >= h_start)
      && (q.hcnt_q < h_start + q.lwid_q)
      && (q.vcnt_q >= v_start)
      && (q.vcnt_q < v_start + q.shgt_q);
  assign de_sel = (link_mode_i && q.auto_q[opt_cfg_pkg::FORCE_DE_BIT])
      ? gen_de : link_de_i;

  always_comb begin
    d = q;
    d.ack_q = 1'b0;
    d.pd_s_q = {q.pd_s_q[0], power_down_pin_i};
    d.sd_s_q = {q.sd_s_q[0], sync_detected_i};
    // registers stay writable in every power state
    if (reg_wr_i) begin
      d.ack_q = 1'b1;
      unique case (reg_addr_i)
        opt_cfg_pkg::SEC_OUT_CTRL_ADDR: d.sec_q = reg_wdata_i;
        opt_cfg_pkg::TRI_PWR_ADDR:      d.tri_q = reg_wdata_i;
        opt_cfg_pkg::AUTO_PWR_ADDR:     d.auto_q = reg_wdata_i;
        opt_cfg_pkg::VDLY_HDLYH_ADDR: begin
          d.vdly_q = reg_wdata_i[7:2];
          d.hdly_q[9:8] = reg_wdata_i[1:0];
        end
        opt_cfg_pkg::HDLY_LOW_ADDR:  d.hdly_q[7:0] = reg_wdata_i;
        opt_cfg_pkg::LWID_HIGH_ADDR: d.lwid_q[11:8] = reg_wdata_i[3:0];
        opt_cfg_pkg::LWID_LOW_ADDR:  d.lwid_q[7:0] = reg_wdata_i;
        opt_cfg_pkg::SHGT_HIGH_ADDR: d.shgt_q[11:8] = reg_wdata_i[3:0];
        opt_cfg_pkg::SHGT_LOW_ADDR:  d.shgt_q[7:0] = reg_wdata_i;
        opt_cfg_pkg::AUD_CFG_ADDR:   d.aud_q = reg_wdata_i;
        default: d.ack_q = 1'b1;
      endcase
    end
    if (reg_rd_i) begin
      d.ack_q = 1'b1;
      unique case (reg_addr_i)
        opt_cfg_pkg::SEC_OUT_CTRL_ADDR: d.rdata_q = q.sec_q;
        opt_cfg_pkg::TRI_PWR_ADDR:      d.rdata_q = q.tri_q;
        opt_cfg_pkg::AUTO_PWR_ADDR:     d.rdata_q = q.auto_q;
        opt_cfg_pkg::VDLY_HDLYH_ADDR:
          d.rdata_q = {q.vdly_q, q.hdly_q[9:8]};
        opt_cfg_pkg::HDLY_LOW_ADDR:  d.rdata_q = q.hdly_q[7:0];
        opt_cfg_pkg::LWID_HIGH_ADDR: d.rdata_q = {4'h0, q.lwid_q[11:8]};
        opt_cfg_pkg::LWID_LOW_ADDR:  d.rdata_q = q.lwid_q[7:0];
        opt_cfg_pkg::SHGT_HIGH_ADDR: d.rdata_q = {4'h0, q.shgt_q[11:8]};
        opt_cfg_pkg::SHGT_LOW_ADDR:  d.rdata_q = q.shgt_q[7:0];
        opt_cfg_pkg::AUD_CFG_ADDR:   d.rdata_q = q.aud_q;
        opt_cfg_pkg::LINK_STAT_ADDR: d.rdata_q = status;
        default:                     d.rdata_q = 8'h00;
      endcase
    end
    // sync edge detection keeps running in power-down
    d.hs_q = link_hsync_i;
    d.vs_q = link_vsync_i;
    if (link_hsync_i && !q.hs_q) begin
      d.hcnt_q = 12'h000;
      d.vcnt_q = q.vcnt_q + 12'h001;
    end else if (q.hcnt_q != 12'hFFF) begin
      d.hcnt_q = q.hcnt_q + 12'h001;
    end
    if (link_vsync_i && !q.vs_q) begin
      d.vcnt_q = 12'h000;
      d.field_q = !q.field_q;
    end
    d.de_q = de_sel;
    // marker one cycle at each active edge
    d.mark_q = q.auto_q[opt_cfg_pkg::BT656_BIT]
        && (de_sel != q.de_q);
    d.clk_q = !q.clk_q;
    // secondary carried on blue lanes in 4:2:2 and ddr 4:4:4
    d.data_q = {6'h00, pixel_i};
    if (out_mode_i == 2'h1 || out_mode_i == 2'h2) begin
      d.data_q[7:0] = secondary_i;
    end
    d.hso_q = link_hsync_i;
    d.vso_q = link_vsync_i;
    d.sog_q = sog_i;
    d.spdif_q = spdif_i;
    d.i2s_q = q.aud_q[opt_cfg_pkg::CTRL_EN_BIT]
        ? link_ctrl_i : i2s_audio_i;
    if (srst_i) begin
      d = '0;
      d.sec_q = opt_cfg_pkg::SEC_OUT_RST;
      d.tri_q = opt_cfg_pkg::TRI_PWR_RST;
      d.auto_q = opt_cfg_pkg::AUTO_PWR_RST;
      d.vdly_q = opt_cfg_pkg::VDLY_RST;
      d.hdly_q = opt_cfg_pkg::HDLY_RST;
      d.lwid_q = opt_cfg_pkg::LWID_RST;
      d.shgt_q = opt_cfg_pkg::SHGT_RST;
      d.aud_q = opt_cfg_pkg::AUD_CFG_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= d;
  end

  assign reg_rdata_o = q.rdata_q;
  assign reg_ack_o = q.ack_q;
  assign data_o = q.data_q;
  // secondary lanes also need their own enable
  assign data_oe_o = {{22{main_oe}},
      {8{main_oe && q.sec_q[opt_cfg_pkg::SEC_EN_BIT]}}};
  assign horizontal_sync_output_o = q.hso_q;
  assign vertical_sync_output_o = q.vso_q;
  assign output_pixel_clock_o = q.clk_q;
  assign sync_io_oe_o = main_oe;
  assign display_enable_o = q.de_q;
  assign sync_on_green_output_o = q.sog_q;
  assign sog_oe_o = sog_oe;
  assign i2s_o = q.i2s_q;
  assign i2s_oe_o = main_oe && !q.tri_q[opt_cfg_pkg::I2S_TRI_BIT];
  assign spdif_o = q.spdif_q;
  assign spdif_oe_o = main_oe && !q.tri_q[opt_cfg_pkg::SPDIF_TRI_BIT];
  assign key_exchange_address_lsb_o =
      q.auto_q[opt_cfg_pkg::KEY_LSB_BIT];
  // other party must lock external clock
  assign ext_mclk_sel_o = q.auto_q[opt_cfg_pkg::EXT_MCLK_BIT];
  assign chip_powered_o = powered;
  assign bt656_marker_o = q.mark_q;
  assign aud_mode_o = q.aud_q[opt_cfg_pkg::AUD_MODE_LSB +: 2];
  assign aud_width_o = q.aud_q[4:0];

  glb_tri_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::GLB_TRI_BIT] |-> !sync_io_oe_o && !i2s_oe_o)
    else $error("global float not applied");
  sw_pd_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::SW_PD_BIT] && !pd_all
      && !q.tri_q[opt_cfg_pkg::SOG_TRI_BIT] |-> sog_oe_o && !data_oe_o[29])
    else $error("software power-down floats wrong");
  sec_en_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !q.sec_q[opt_cfg_pkg::SEC_EN_BIT] |-> data_oe_o[7:0] == 8'h00)
    else $error("secondary driven while disabled");
  pin_idle_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !pin_act && !q.tri_q[opt_cfg_pkg::GLB_TRI_BIT]
      && !q.tri_q[opt_cfg_pkg::SW_PD_BIT] |-> sync_io_oe_o)
    else $error("pin function acted while idle");
  pin_all_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    pin_act && q.tri_q[opt_cfg_pkg::PD_FN_LSB] |-> !sog_oe_o)
    else $error("all-float function kept sog");
  ctrl_sel_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.aud_q[opt_cfg_pkg::CTRL_EN_BIT] && !srst_i
      |=> i2s_o == $past(link_ctrl_i))
    else $error("control not routed to i2s");
  mark_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !q.auto_q[opt_cfg_pkg::BT656_BIT] ##1 !q.auto_q[opt_cfg_pkg::BT656_BIT]
      |-> !bt656_marker_o)
    else $error("marker without bt656 mode");
  spdif_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::SPDIF_TRI_BIT] |-> !spdif_oe_o)
    else $error("spdif driven while floated");
  i2s_tri_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::I2S_TRI_BIT] |-> !i2s_oe_o)
    else $error("i2s driven while floated");
  sog_tri_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::SOG_TRI_BIT] |-> !sog_oe_o)
    else $error("sog driven while floated");
  glb_data_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::GLB_TRI_BIT] |-> data_oe_o == 30'h0)
    else $error("data driven under global float");
  sw_data_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.tri_q[opt_cfg_pkg::SW_PD_BIT] |-> data_oe_o == 30'h0
      && !sync_io_oe_o)
    else $error("data driven in software power-down");
  pin_main_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    pin_act |-> !sync_io_oe_o && data_oe_o == 30'h0)
    else $error("main outputs driven with pin asserted");
  pin_soga_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    pin_act && !q.tri_q[opt_cfg_pkg::PD_FN_LSB]
      && !q.tri_q[opt_cfg_pkg::SOG_TRI_BIT] |-> sog_oe_o)
    else $error("sog floated by keep-sog function");
  pin_pwr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    pin_act && !q.tri_q[opt_cfg_pkg::PD_FN_LSB+1] |-> !chip_powered_o)
    else $error("pin function failed to power down");
  auto_pd_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    q.auto_q[opt_cfg_pkg::AUTO_PD_BIT] && !q.sd_s_q[1]
      |-> !chip_powered_o)
    else $error("auto power-down not applied");
  bus_ack_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_wr_i || reg_rd_i |=> reg_ack_o)
    else $error("register access not acknowledged");
  stat_rd_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == opt_cfg_pkg::LINK_STAT_ADDR
      |=> reg_rdata_o == $past(status))
    else $error("status read wrong");
  gen_de_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    link_mode_i && q.auto_q[opt_cfg_pkg::FORCE_DE_BIT]
      |=> display_enable_o == $past(gen_de))
    else $error("generator enable not used");
  hcnt_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    link_hsync_i && !q.hs_q |=> q.hcnt_q == 12'h000)
    else $error("pixel count not restarted");
  vcnt_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    link_vsync_i && !q.vs_q |=> q.vcnt_q == 12'h000)
    else $error("line count not restarted");
  prim_data_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    out_mode_i == 2'h0 |=> data_o == {6'h00, $past(pixel_i)})
    else $error("primary data not passed");
  sec_lane_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    out_mode_i == 2'h1 |=> data_o[7:0] == $past(secondary_i))
    else $error("secondary not on blue lanes");
  i2s_pass_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !q.aud_q[opt_cfg_pkg::CTRL_EN_BIT] |=> i2s_o == $past(i2s_audio_i))
    else $error("audio not routed to i2s");
  rst_val_a: assert property (@(posedge mclk_i)
    srst_i |=> q.tri_q == opt_cfg_pkg::TRI_PWR_RST
      && q.auto_q == opt_cfg_pkg::AUTO_PWR_RST
      && q.sec_q == opt_cfg_pkg::SEC_OUT_RST)
    else $error("reset values not loaded");
endmodule : output_power_timing_config_regs
